// ---- pwm_out_pkg.sv ----
// pwm output-stage package: register map, field layout, carriers
// assumes one pwm generator per instance, 16-bit registers
package pwm_out_pkg;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [3:0] ADR_ALT_DT   = 4'h0;
    localparam logic [3:0] ADR_TRG_CON  = 4'h1;
    localparam logic [3:0] ADR_IO_CON   = 4'h2;
    localparam logic [3:0] ADR_FCL_CON  = 4'h3;
    localparam logic [3:0] ADR_TRG_CMP  = 4'h4;
    localparam logic [3:0] ADR_DT_CTL   = 4'h5;
    localparam logic [3:0] ADR_STATUS   = 4'h6;

    // writable bit masks, unimplemented bits read zero
    localparam logic [15:0] MSK_ALT_DT  = 16'h3ffc;
    localparam logic [15:0] MSK_TRG_CON = 16'he03f;
    localparam logic [15:0] MSK_IO_CON  = 16'hfffd;
    localparam logic [15:0] MSK_FCL_CON = 16'h1fff;
    localparam logic [15:0] MSK_TRG_CMP = 16'hfff8;
    localparam logic [15:0] RST_REG     = 16'h0000;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ALT_HI = 13, ALT_LO = 2;
    localparam int TDIV_HI = 15, TDIV_LO = 13;
    localparam int TSTRT_HI = 5, TSTRT_LO = 0;
    localparam int CMP_HI = 15, CMP_LO = 3;
    localparam int IO_OWNH = 15, IO_OWNL = 14;
    localparam int IO_HIGH_PIN_POLARITY = 13, IO_POLL = 12;
    localparam int PIN_PAIR_MODE_HI = 11, PIN_PAIR_MODE_LO = 10;
    localparam int OVEN_HI = 9, OVEN_LO = 8;
    localparam int OVD_HI = 7, OVD_LO = 6;
    localparam int FDAT_HI = 5, FDAT_LO = 4;
    localparam int LDAT_HI = 3, LDAT_LO = 2;
    localparam int IO_OVERRIDE_SYNC = 0;
    localparam int LSRC_HI = 12, LSRC_LO = 9;
    localparam int LPOL = 8, LMODE = 7;
    localparam int FSRC_HI = 6, FSRC_LO = 3;
    localparam int FPOL = 2;
    localparam int FMOD_HI = 1, FMOD_LO = 0;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] PM_COMPL = 2'h0;
    localparam logic [1:0] PM_INDEP = 2'h1;
    localparam logic [1:0] PM_PUSH  = 2'h2;
    localparam logic [1:0] FM_CYCLE = 2'h1;
    localparam logic [1:0] DT_RSVD  = 2'h3;
    localparam logic [3:0] SRC_IF2  = 4'hd;
    localparam logic [3:0] SRC_IF4  = 4'hf;
    localparam logic [2:0] CNT_ZERO = 3'h0;
    localparam logic [2:0] CNT_ONE  = 3'h1;

    // external fault and comparator inputs
    typedef struct packed {
        logic [3:0] cmp;
        logic [3:0] sflt;
        logic       if2;
        logic       if4;
    } src_type;

    // pin pair value, high side first
    typedef struct packed {
        logic h;
        logic l;
    } pair_type;

endpackage : pwm_out_pkg

// ---- pwm_out_ctrl.sv ----
// pwm output-stage control: dead time value, trigger postscaler,
// pin ownership, polarity, pair mode, overrides, fault and limit
// assumes time base, roll counter and generator data come from logic
// on CLK; comparator and fault inputs are asynchronous pins
//
// Operation
// - alternate dead time is an unsigned field in bits 13..2, rest zero
// - trigger divider gives one output per N+1 trigger events
// - postscaler starts counting once roll counter equals start select
// - ownership bit one gives pin to pwm, zero gives it to gpio
// - polarity bit zero means active high, one means active low
// - pair mode: 00 complementary, 01 independent, 10 push-pull
// - override enables put override data bits on high and low pins
// - override sync set waits for cycle start, clear takes next clock
// - active fault drives pins from fault data bits
// - active current limit drives pins from limit data bits
// - limit source: comparators, shared faults, independent faults 2 and 4
// - limit polarity bit selects active high or active low source
// - limit acts only while its enable bit is one
// - fault source uses the same encoding as the limit source
// - fault polarity bit selects active high or active low source
// - fault mode 01 forces pins per cycle, 11 disables the fault
// - limit override holds until the next pwm cycle begins
// - trigger event when time base matches trigger compare value
// - dead time select: positive, negative, none, 11 reserved
`timescale 1ns/1ps
`default_nettype none

module pwm_out_ctrl
    import pwm_out_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output var  logic [15:0] RDATA,
    input  wire logic [15:0] TIME_BASE,
    input  wire logic [5:0]  ROLL_COUNT,
    input  wire logic        CYCLE_START,
    input  wire logic        GEN_HIGH,
    input  wire logic        GEN_LOW,
    input  wire logic        GPIO_HIGH,
    input  wire logic        GPIO_LOW,
    input  wire src_type     SRC_PINS,
    output var  logic        HIGH_SIDE_OUT,
    output var  logic        LOW_SIDE_OUT,
    output var  logic        TRIG_OUT,
    output var  logic [11:0] ALT_DEAD_TIME,
    output var  logic [1:0]  DEAD_TIME_SEL
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] alt_dt;
        logic [15:0] trg_con;
        logic [15:0] io_con;
        logic [15:0] fcl_con;
        logic [15:0] trg_cmp;
        logic [1:0]  dt_ctl;
        logic [1:0]  ovr_en;
        logic [1:0]  ovr_dat;
        src_type     sync1;
        src_type     sync2;
        logic        flt_lat;
        logic        lim_lat;
        logic        tb_match;
        logic        armed;
        logic [2:0]  post_cnt;
        logic        push_ph;
        pair_type    pin;
        logic        trig;
        logic [15:0] rdata;
    } state_type;

    state_type st_q;
    state_type st_d;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // selected source level; valid low on reserved codes
    function automatic logic [1:0] src_pick(
        input logic [3:0] code,
        input src_type    s
    );
        logic [1:0] r;
        r = 2'b00;
        if (code[3:2] == 2'b00)
        begin
            r = {1'b1, s.cmp[code[1:0]]};
        end
        else if (code[3:2] == 2'b10)
        begin
            r = {1'b1, s.sflt[code[1:0]]};
        end
        else if (code == SRC_IF2)
        begin
            r = {1'b1, s.if2};
        end
        else if (code == SRC_IF4)
        begin
            r = {1'b1, s.if4};
        end
        return r;
    endfunction : src_pick

    // register write with unimplemented bits kept at zero
    function automatic logic [15:0] wr_mask(
        input logic [15:0] d,
        input logic [15:0] m
    );
        return d & m;
    endfunction : wr_mask

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [1:0] lim_src;
    logic [1:0] flt_src;
    logic       lim_now;
    logic       flt_now;
    logic       match;
    logic       event_p;
    logic       ovr_take;
    pair_type   gen;
    pair_type   mux;

    always_comb
    begin
        st_d = st_q;
        st_d.trig = 1'b0;
        st_d.rdata = RST_REG;

        // two-flop synchroniser for asynchronous source pins
        st_d.sync1 = SRC_PINS;
        st_d.sync2 = st_q.sync1;

        // register writes
        if (WR)
        begin
            if (ADDR == ADR_ALT_DT)
            begin
                st_d.alt_dt = wr_mask(WDATA, MSK_ALT_DT);
            end
            else if (ADDR == ADR_TRG_CON)
            begin
                st_d.trg_con = wr_mask(WDATA, MSK_TRG_CON);
                st_d.armed = 1'b0;  // new start select clears the arm
            end
            else if (ADDR == ADR_IO_CON)
            begin
                st_d.io_con = wr_mask(WDATA, MSK_IO_CON);
            end
            else if (ADDR == ADR_FCL_CON)
            begin
                st_d.fcl_con = wr_mask(WDATA, MSK_FCL_CON);
            end
            else if (ADDR == ADR_TRG_CMP)
            begin
                st_d.trg_cmp = wr_mask(WDATA, MSK_TRG_CMP);
            end
            else if (ADDR == ADR_DT_CTL)
            begin
                st_d.dt_ctl = WDATA[1:0];
            end
        end

        // register reads, data stands in the next cycle only
        if (RD)
        begin
            if (ADDR == ADR_ALT_DT)
            begin
                st_d.rdata = st_q.alt_dt;
            end
            else if (ADDR == ADR_TRG_CON)
            begin
                st_d.rdata = st_q.trg_con;
            end
            else if (ADDR == ADR_IO_CON)
            begin
                st_d.rdata = st_q.io_con;
            end
            else if (ADDR == ADR_FCL_CON)
            begin
                st_d.rdata = st_q.fcl_con;
            end
            else if (ADDR == ADR_TRG_CMP)
            begin
                st_d.rdata = st_q.trg_cmp;
            end
            else if (ADDR == ADR_DT_CTL)
            begin
                st_d.rdata = {14'h0000, st_q.dt_ctl};
            end
            else if (ADDR == ADR_STATUS)
            begin
                st_d.rdata = {8'h00, st_q.flt_lat, st_q.lim_lat,
                              st_q.armed, st_q.push_ph, 1'b0,
                              st_q.post_cnt};
            end
        end

        // source selection and polarity; reserved codes never assert
        lim_src = src_pick(st_q.fcl_con[LSRC_HI:LSRC_LO], st_q.sync2);
        flt_src = src_pick(st_q.fcl_con[FSRC_HI:FSRC_LO], st_q.sync2);
        lim_now = lim_src[1] & st_q.fcl_con[LMODE]
                & (lim_src[0] ^ st_q.fcl_con[LPOL]);
        flt_now = flt_src[1]
                & (st_q.fcl_con[FMOD_HI:FMOD_LO] == FM_CYCLE)
                & (flt_src[0] ^ st_q.fcl_con[FPOL]);

        // latched until the next cycle start; a new hit wins the clear
        st_d.lim_lat = lim_now | (st_q.lim_lat & ~CYCLE_START);
        st_d.flt_lat = flt_now | (st_q.flt_lat & ~CYCLE_START);

        // override data: cycle start when synced, else next clock
        ovr_take = ~st_q.io_con[IO_OVERRIDE_SYNC] | CYCLE_START;
        if (ovr_take)
        begin
            st_d.ovr_en = st_q.io_con[OVEN_HI:OVEN_LO];
            st_d.ovr_dat = st_q.io_con[OVD_HI:OVD_LO];
        end

        // push-pull phase alternates every pwm cycle
        if (CYCLE_START)
        begin
            st_d.push_ph = ~st_q.push_ph;
        end

        // trigger event on the first cycle of a compare match
        match = TIME_BASE[CMP_HI:CMP_LO] == st_q.trg_cmp[CMP_HI:CMP_LO];
        st_d.tb_match = match;
        event_p = match & ~st_q.tb_match;

        // postscaler enabled once roll count hits start select
        // a write to trigger control clears the arm and must not be undone here
        if (ROLL_COUNT == st_q.trg_con[TSTRT_HI:TSTRT_LO]
            && !(WR && ADDR == ADR_TRG_CON))
        begin
            st_d.armed = 1'b1;
        end
        if (event_p && st_q.armed)
        begin
            if (st_q.post_cnt == st_q.trg_con[TDIV_HI:TDIV_LO])
            begin
                st_d.post_cnt = CNT_ZERO;
                st_d.trig = 1'b1;
            end
            else
            begin
                st_d.post_cnt = st_q.post_cnt + CNT_ONE;
            end
        end

        // generator data shaped by pair mode; reserved drives inactive
        gen = '0;
        case (st_q.io_con[PIN_PAIR_MODE_HI:PIN_PAIR_MODE_LO])
            PM_COMPL:
            begin
                gen = {GEN_HIGH, ~GEN_HIGH};
            end
            PM_INDEP:
            begin
                gen = {GEN_HIGH, GEN_LOW};
            end
            PM_PUSH:
            begin
                gen = {GEN_HIGH & ~st_q.push_ph,
                       GEN_HIGH & st_q.push_ph};
            end
            default:
            begin
                gen = '0;
            end
        endcase

        // priority chain, lowest first so later steps win
        mux = gen;
        if (st_q.ovr_en[1])
        begin
            mux.h = st_q.ovr_dat[1];
        end
        if (st_q.ovr_en[0])
        begin
            mux.l = st_q.ovr_dat[0];
        end
        if (st_q.lim_lat)
        begin
            mux = st_q.io_con[LDAT_HI:LDAT_LO];
        end
        if (st_q.flt_lat)
        begin
            mux = st_q.io_con[FDAT_HI:FDAT_LO];
        end

        // polarity applied last, then ownership picks pwm or gpio
        mux.h = mux.h ^ st_q.io_con[IO_HIGH_PIN_POLARITY];
        mux.l = mux.l ^ st_q.io_con[IO_POLL];
        st_d.pin.h = st_q.io_con[IO_OWNH] ? mux.h : GPIO_HIGH;
        st_d.pin.l = st_q.io_con[IO_OWNL] ? mux.l : GPIO_LOW;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------

    // clock enable low freezes every bit; reset still clears them whatever the enable
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st_q <= '0;
        end
        else if (CE)
        begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------------------------------
    assign RDATA         = st_q.rdata;
    assign HIGH_SIDE_OUT = st_q.pin.h;
    assign LOW_SIDE_OUT  = st_q.pin.l;
    assign TRIG_OUT      = st_q.trig;
    assign ALT_DEAD_TIME = st_q.alt_dt[ALT_HI:ALT_LO];
    assign DEAD_TIME_SEL = st_q.dt_ctl;

endmodule : pwm_out_ctrl

`default_nettype wire

// ---- src_far.sv ----
// far-side model: comparator and fault lines feeding the output stage
// assumes the bench picks one line and its level; the rest idle low
`timescale 1ns/1ps
`default_nettype none

module src_far
    import pwm_out_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [3:0] code,
    input  wire logic       lvl,
    output var  src_type    pins
);
    // lines start low so the synchronisers never see an unknown
    initial pins = '0;

    // only the chosen line moves, just after the edge like a real pin
    always @(posedge clk)
    begin
        pins <= '0;
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3: pins.cmp[code[1:0]] <= lvl;
            4'h8, 4'h9, 4'ha, 4'hb: pins.sflt[code[1:0]] <= lvl;
            SRC_IF2:                pins.if2 <= lvl;
            SRC_IF4:                pins.if4 <= lvl;
            default:                pins <= '0;
        endcase
    end
endmodule : src_far
`default_nettype wire

// ---- pwm_out_ctrl_sva.sv ----
// checker for the pwm output-stage control block
// assumes it is bound to the block and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module pwm_out_ctrl_sva
    import pwm_out_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        CE,
    input wire logic [3:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic [15:0] TIME_BASE,
    input wire logic [5:0]  ROLL_COUNT,
    input wire logic        CYCLE_START,
    input wire logic        GEN_HIGH,
    input wire logic        GEN_LOW,
    input wire logic        GPIO_HIGH,
    input wire logic        GPIO_LOW,
    input wire src_type     SRC_PINS,
    input wire logic        HIGH_SIDE_OUT,
    input wire logic        LOW_SIDE_OUT,
    input wire logic        TRIG_OUT,
    input wire logic [11:0] ALT_DEAD_TIME,
    input wire logic [1:0]  DEAD_TIME_SEL
);
    logic [15:0] alt_q, io_q, fcl_q, cmp_q;
    logic [1:0]  dt_q, fsel, lsel, pins;
    logic [2:0]  age_q;
    logic        hit, own, f_act, l_act;

    // {valid, level} of the line a source code names; reserved codes are invalid
    function automatic logic [1:0] pick(input logic [3:0] c, input src_type s);
        case (c)
            4'h0, 4'h1, 4'h2, 4'h3: pick = {1'b1, s.cmp[c[1:0]]};
            4'h8, 4'h9, 4'ha, 4'hb: pick = {1'b1, s.sflt[c[1:0]]};
            SRC_IF2:                pick = {1'b1, s.if2};
            SRC_IF4:                pick = {1'b1, s.if4};
            default:                pick = 2'b00;
        endcase
    endfunction : pick

    // --------------------------------
    // shadow registers
    // --------------------------------
    // age saturates at 7 so pin checks wait out every pipeline stage
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            alt_q <= '0;
            io_q  <= '0;
            fcl_q <= '0;
            cmp_q <= '0;
            dt_q  <= '0;
            age_q <= '0;
        end
        else if (CE && WR)
        begin
            age_q <= '0;
            if (ADDR == ADR_ALT_DT) alt_q <= WDATA;
            if (ADDR == ADR_IO_CON) io_q <= WDATA;
            if (ADDR == ADR_FCL_CON) fcl_q <= WDATA;
            if (ADDR == ADR_TRG_CMP) cmp_q <= WDATA;
            if (ADDR == ADR_DT_CTL) dt_q <= WDATA[1:0];
        end
        else if (age_q != 3'h7)
            age_q <= age_q + 3'h1;
    end

    // source activity as the rules define it, before any synchronising
    assign fsel  = pick(fcl_q[FSRC_HI:FSRC_LO], SRC_PINS);
    assign lsel  = pick(fcl_q[LSRC_HI:LSRC_LO], SRC_PINS);
    assign f_act = fsel[1] && (fsel[0] ^ fcl_q[FPOL]) && fcl_q[1:0] == FM_CYCLE;
    assign l_act = lsel[1] && (lsel[0] ^ fcl_q[LPOL]) && fcl_q[LMODE] && fcl_q[1:0] != FM_CYCLE;
    assign own   = age_q == 3'h7 && io_q[IO_OWNH] && io_q[IO_OWNL];
    assign hit   = TIME_BASE[15:3] == cmp_q[15:3];
    assign pins  = {HIGH_SIDE_OUT, LOW_SIDE_OUT};

    // --------------------------------
    // assertions
    // --------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_rdata_idle: assert property (!RD |=> RDATA == 16'h0000)
        else $error("read data not zero outside a read");
    a_unmapped_read: assert property (RD && ADDR > ADR_STATUS |=> RDATA == 16'h0000)
        else $error("unmapped read not zero");
    a_trg_unused: assert property (RD && ADDR == ADR_TRG_CON |=> RDATA[12:6] == 7'h00)
        else $error("trigger control unused bits not zero");
    a_alt_value: assert property (age_q == 3'h7 |-> ALT_DEAD_TIME == alt_q[13:2])
        else $error("dead time value output wrong");
    a_dt_select: assert property (age_q == 3'h7 && dt_q != DT_RSVD |-> DEAD_TIME_SEL == dt_q)
        else $error("dead time select output wrong");
    a_gpio_high: assert property (age_q == 3'h7 && !io_q[IO_OWNH] |-> HIGH_SIDE_OUT == $past(GPIO_HIGH))
        else $error("high pin not following gpio");
    a_override_pins: assert property (own && io_q[9:8] == 2'b11 && !io_q[IO_OVERRIDE_SYNC] && !fcl_q[LMODE] && fcl_q[1:0] != FM_CYCLE |-> pins == (io_q[7:6] ^ io_q[13:12]))
        else $error("override data not on pins");
    a_fault_force: assert property ((own && f_act)[*6] |-> pins == (io_q[5:4] ^ io_q[13:12]))
        else $error("fault data not forced");
    a_limit_force: assert property ((own && l_act)[*6] |-> pins == (io_q[3:2] ^ io_q[13:12]))
        else $error("limit data not forced");
    a_trig_cause: assert property (TRIG_OUT |-> $past(hit) || $past(hit, 2))
        else $error("trigger without compare match");
endmodule : pwm_out_ctrl_sva

bind pwm_out_ctrl pwm_out_ctrl_sva chk_i (
    .CLK, .RST, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA, .TIME_BASE, .ROLL_COUNT,
    .CYCLE_START, .GEN_HIGH, .GEN_LOW, .GPIO_HIGH, .GPIO_LOW, .SRC_PINS,
    .HIGH_SIDE_OUT, .LOW_SIDE_OUT, .TRIG_OUT, .ALT_DEAD_TIME, .DEAD_TIME_SEL
);
`default_nettype wire

// ---- pwm_out_ctrl_tb.sv ----
// self-checking bench for the pwm output-stage control block
// assumes package, design, far-side model and checker compiled first
`timescale 1ns/1ps
`default_nettype none

module pwm_out_ctrl_tb
    import pwm_out_pkg::*;
();
    logic        CLK, RST, WR, RD, CYCLE_START, GEN_HIGH, GEN_LOW, GPIO_HIGH, GPIO_LOW;
    logic        HIGH_SIDE_OUT, LOW_SIDE_OUT, TRIG_OUT, lvl;
    logic [3:0]  ADDR, code;
    logic [15:0] WDATA, RDATA, TIME_BASE;
    logic [5:0]  ROLL_COUNT;
    logic [11:0] ALT_DEAD_TIME;
    logic [1:0]  DEAD_TIME_SEL;
    src_type     SRC_PINS;
    logic [31:0] seed;
    logic [3:0]  codes [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb, 4'hd, 4'hf, 4'h4, 4'he};
    int          n_mismatch, checks, n_trig;

    pwm_out_ctrl DUT (
        .CLK, .RST, .CE(1'b1), .ADDR, .WDATA, .WR, .RD, .RDATA, .TIME_BASE, .ROLL_COUNT,
        .CYCLE_START, .GEN_HIGH, .GEN_LOW, .GPIO_HIGH, .GPIO_LOW, .SRC_PINS,
        .HIGH_SIDE_OUT, .LOW_SIDE_OUT, .TRIG_OUT, .ALT_DEAD_TIME, .DEAD_TIME_SEL
    );
    src_far far_i (.clk(CLK), .code, .lvl, .pins(SRC_PINS));

    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    // trigger pulses counted mid-cycle, away from the edge that launches them
    always @(negedge CLK)
        if (TRIG_OUT === 1'b1) n_trig++;

    // --------------------------------
    // helpers
    // --------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [15:0] rmask(input logic [3:0] a);
        case (a)
            ADR_ALT_DT:  rmask = MSK_ALT_DT;
            ADR_TRG_CON: rmask = MSK_TRG_CON;
            ADR_IO_CON:  rmask = MSK_IO_CON;
            ADR_FCL_CON: rmask = MSK_FCL_CON;
            ADR_TRG_CMP: rmask = MSK_TRG_CMP;
            default:     rmask = 16'h0000;
        endcase
    endfunction : rmask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
    endtask : tick

    // bus tasks start and end just after an edge; the idle cycle keeps strobes apart
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        WR    <= 1'b1;
        ADDR  <= a;
        WDATA <= d;
        tick(1);
        WR <= 1'b0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        RD   <= 1'b1;
        ADDR <= a;
        tick(1);
        RD <= 1'b0;
        #1 d = RDATA;
        tick(1);
    endtask : rd

    task automatic pins(input logic [1:0] e);
        chk({14'h0, HIGH_SIDE_OUT, LOW_SIDE_OUT}, {14'h0, e});
    endtask : pins

    task automatic cstart;
        CYCLE_START <= 1'b1;
        tick(1);
        CYCLE_START <= 1'b0;
        tick(8);
    endtask : cstart

    task automatic ev;
        TIME_BASE <= 16'h1238;
        tick(1);
        TIME_BASE <= 16'h0000;
        tick(2);
    endtask : ev

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    // a hang ends the run as a failure
    initial
    begin
        tick(60000);
        n_mismatch++;
        $display("BAD %0t run too long", $time);
        finish_test();
    end

    // --------------------------------
    // main sequence
    // --------------------------------
    initial
    begin
        logic [15:0] v;
        logic [3:0]  a;
        logic [5:0]  s;
        {RST, WR, RD, CYCLE_START, GEN_HIGH, GEN_LOW, GPIO_HIGH, GPIO_LOW, lvl} = 9'h100;
        {ADDR, WDATA, TIME_BASE, ROLL_COUNT, code} = '0;
        seed = 32'h6bfe;
        tick(6);
        RST <= 1'b0;
        tick(1);
        for (int i = 0; i < 16; i++)
        begin
            rd(i[3:0], v);
            chk(v, (i == 6) ? 16'h0020 : 16'h0000);
        end
        // random round trips, unmapped place included
        for (int i = 0; i < 12; i++)
        begin
            seed = lfsr(seed);
            a = (i % 6 == 5) ? 4'h9 : 4'(i % 6);
            wr(a, seed[15:0]);
            rd(a, v);
            chk(v, seed[15:0] & rmask(a));
        end
        wr(ADR_ALT_DT, 16'hffff);
        chk({4'h0, ALT_DEAD_TIME}, 16'h0fff);
        for (int i = 0; i < 4; i++)
        begin
            wr(ADR_DT_CTL, 16'(i));
            if (i < 3)
                chk({14'h0, DEAD_TIME_SEL}, 16'(i));
        end
        $display("test registers done");
        wr(ADR_FCL_CON, 16'h0003);
        wr(ADR_IO_CON, 16'h0000);
        cstart();
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            {GPIO_HIGH, GPIO_LOW} <= seed[1:0];
            tick(2);
            pins(seed[1:0]);
        end
        for (int m = 0; m < 4; m++)
        begin
            wr(ADR_IO_CON, {4'hc, 2'(m), 10'h000});
            for (int j = 0; j < 4; j++)
            begin
                seed = lfsr(seed);
                {GEN_HIGH, GEN_LOW} <= seed[1:0];
                tick(2);
                if (m[0])
                    pins(m[1] ? 2'b00 : seed[1:0]);
            end
        end
        $display("test ownership done");
        {GEN_HIGH, GEN_LOW} <= 2'b00;
        for (int i = 0; i < 16; i++)
        begin
            wr(ADR_IO_CON, {2'b11, i[3:2], 4'b0111, i[1:0], 6'h00});
            tick(8);
            pins(i[1:0] ^ i[3:2]);
        end
        // sync set: polarity moves at once, data waits for the cycle start
        wr(ADR_IO_CON, 16'hc701);
        tick(8);
        pins(2'b11);
        cstart();
        pins(2'b00);
        $display("test override done");
        wr(ADR_IO_CON, 16'hc430);
        for (int i = 0; i < 12; i++)
        begin
            wr(ADR_FCL_CON, {9'h000, codes[i], i[0], 2'b01});
            code <= codes[i];
            lvl  <= i[0];
            tick(8);
            cstart();
            lvl <= ~i[0];
            tick(8);
            pins((i < 10) ? 2'b11 : 2'b00);
            lvl <= i[0];
            tick(8);
            cstart();
            pins(2'b00);
        end
        wr(ADR_FCL_CON, 16'h0003);
        code <= 4'h0;
        lvl  <= 1'b1;
        tick(8);
        pins(2'b00);
        $display("test fault done");
        wr(ADR_IO_CON, 16'hc40c);
        code <= SRC_IF2;
        wr(ADR_FCL_CON, {3'h0, SRC_IF2, 9'h183});
        cstart();
        lvl <= 1'b0;
        tick(8);
        pins(2'b11);
        lvl <= 1'b1;
        tick(8);
        pins(2'b11);
        cstart();
        pins(2'b00);
        wr(ADR_FCL_CON, {3'h0, SRC_IF2, 9'h103});
        lvl <= 1'b0;
        tick(8);
        pins(2'b00);
        $display("test limit done");
        wr(ADR_TRG_CMP, 16'h1238);
        for (int n = 0; n < 8; n++)
        begin
            seed = lfsr(seed);
            s = seed[5:0];
            ROLL_COUNT <= s + 6'h1;
            tick(1);
            wr(ADR_TRG_CON, {n[2:0], 7'h00, s});
            n_trig = 0;
            ev();
            ev();
            tick(4);
            chk(16'(n_trig), 16'h0000);
            ROLL_COUNT <= s;
            tick(1);
            ROLL_COUNT <= s + 6'h1;
            repeat (2 * (n + 1)) ev();
            tick(4);
            chk(16'(n_trig), 16'h0002);
        end
        $display("test trigger done");
        finish_test();
    end
endmodule : pwm_out_ctrl_tb
`default_nettype wire
